// ===== verilog/msf_modem_status.sv
// Status flags, interrupt, quality, checksums and tx symbol shaping
//
// The implementer's own choices: the register offsets and the AXI4-Lite interface to the registers.
`timescale 1ns/100ps
module msf_modem_status (
   input  wire logic        core_clk,
   input  wire logic        sys_rst,
   input  wire logic [7:0]  s_axi_awaddr,
   input  wire logic        s_axi_awvalid,
   output logic             s_axi_awready,
   input  wire logic [31:0] s_axi_wdata,
   input  wire logic [3:0]  s_axi_wstrb,
   input  wire logic        s_axi_wvalid,
   output logic             s_axi_wready,
   output logic [1:0]       s_axi_bresp,
   output logic             s_axi_bvalid,
   input  wire logic        s_axi_bready,
   input  wire logic [7:0]  s_axi_araddr,
   input  wire logic        s_axi_arvalid,
   output logic             s_axi_arready,
   output logic [31:0]      s_axi_rdata,
   output logic [1:0]       s_axi_rresp,
   output logic             s_axi_rvalid,
   input  wire logic        s_axi_rready,
   input  wire logic        symTick,
   input  wire logic [1:0]  txSymbol,
   input  wire logic        rxTaskDone,
   input  wire logic        rxCrcBad,
   input  wire logic        rxLate,
   input  wire logic [7:0]  rxErrMag,
   output logic [2:0]       shapeLevel,
   output logic             rxEqImpulse,
   output logic             interruptOutLow,
   output logic             interruptOutOe
);

   ////////////////////////////////////////////////////////////////////////
   // AXI4-Lite write path
   logic [7:0]  awAddr_ff;
   logic        awHeld_ff;
   logic [31:0] wData_ff;
   logic        wStrb0_ff;
   logic        wHeld_ff;
   logic        bValid_ff;
   logic [1:0]  bResp_ff;
   wire         doWrite = awHeld_ff & wHeld_ff & ~bValid_ff;
   wire  [7:0]  wByte = wData_ff[7:0];
   wire         wLane = wStrb0_ff;
   wire         wrCmd  = doWrite & wLane & (awAddr_ff == msf_pkg::OFF_COMMAND);
   wire         wrMode = doWrite & wLane & (awAddr_ff == msf_pkg::OFF_MODE);
   wire         wrData = doWrite & wLane & (awAddr_ff == msf_pkg::OFF_DATA);
   wire         wMapped = (awAddr_ff == msf_pkg::OFF_COMMAND) |
                          (awAddr_ff == msf_pkg::OFF_MODE) |
                          (awAddr_ff == msf_pkg::OFF_DATA);

   assign s_axi_awready = ~awHeld_ff;
   assign s_axi_wready  = ~wHeld_ff;
   assign s_axi_bvalid  = bValid_ff;
   assign s_axi_bresp   = bResp_ff;

   // Address and data may arrive in either order
   always_ff @(posedge core_clk) begin
      if (sys_rst) begin
         awHeld_ff <= 1'b0;
         wHeld_ff  <= 1'b0;
         bValid_ff <= 1'b0;
         awAddr_ff <= 8'h00;
         wData_ff  <= 32'h00000000;
         wStrb0_ff <= 1'b0;
         bResp_ff  <= 2'h0;
      end else begin
         if (s_axi_awvalid & ~awHeld_ff) begin
            awHeld_ff <= 1'b1;
            awAddr_ff <= {s_axi_awaddr[7:2], 2'b00};
         end else if (doWrite) begin
            awHeld_ff <= 1'b0;
         end
         if (s_axi_wvalid & ~wHeld_ff) begin
            wHeld_ff  <= 1'b1;
            wData_ff  <= s_axi_wdata;
            wStrb0_ff <= s_axi_wstrb[0];
         end else if (doWrite) begin
            wHeld_ff <= 1'b0;
         end
         if (doWrite) begin
            bValid_ff <= 1'b1;
            bResp_ff  <= wMapped ? msf_pkg::RESP_OKAY : msf_pkg::RESP_SLVERR;
         end else if (s_axi_bready) begin
            bValid_ff <= 1'b0;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Command and mode decoding
   msf_pkg::msf_cmd_t  cmd_ff;
   msf_pkg::msf_mode_t mode_ff;
   wire msf_pkg::msf_cmd_t  newCmd  = msf_pkg::msf_cmd_t'(wByte);
   wire msf_pkg::msf_mode_t newMode = msf_pkg::msf_mode_t'(wByte);
   wire [3:0] newTask = newCmd.taskCode;
   wire isTx = mode_ff.txSelect;                               // [RULE_23]
   wire modeFlip = wrMode & ((newMode.txSelect != mode_ff.txSelect) |
                             (newMode.powersave != mode_ff.powersave));
   wire resetTask = wrCmd & (newTask == msf_pkg::TSK_RESET);
   wire quietSet  = modeFlip | resetTask;     // Sets flags with no interrupt
   wire realTask  = wrCmd & (newTask != msf_pkg::TSK_NULL) & ~resetTask;
   wire rxLateTask = realTask & ~isTx & rxLate &
                     ((newTask == msf_pkg::TSK_RHB) |
                      (newTask == msf_pkg::TSK_MID_LAST_RECEIVE_TASK) |
                      (newTask == msf_pkg::TSK_R4S));

   always_ff @(posedge core_clk) begin
      if (sys_rst) begin
         cmd_ff  <= msf_pkg::msf_cmd_t'(msf_pkg::CMD_RESET);
         mode_ff <= msf_pkg::msf_mode_t'(msf_pkg::MODE_RESET);
      end else begin
         if (wrCmd) cmd_ff <= newCmd;
         if (wrMode) mode_ff <= newMode;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Task sequencing and interleave occupancy
   logic [3:0] pendTask_ff;
   logic       pending_ff;
   logic [6:0] ilCount_ff;
   logic [3:0] runTask_ff;
   logic       running_ff;
   wire        txLoad = isTx & symTick & pending_ff &
                        (ilCount_ff < msf_pkg::LOW_MARK);
   wire        txDone = isTx & symTick & running_ff &
                        (ilCount_ff == 7'h01);
   wire        rxDone = ~isTx & pending_ff & rxTaskDone;
   wire        taskDone = txDone | rxDone;
   wire [3:0]  doneTask = isTx ? runTask_ff : pendTask_ff;
   wire        shortTask = (pendTask_ff == msf_pkg::TSK_T4S);
   // Block tasks occupy 66 interleaved symbols
   wire [6:0]  loadSyms = shortTask ? msf_pkg::SHORT_SYMS
                                    : msf_pkg::BLOCK_SYMS;  // [RULE_20][RULE_21]

   // Mode change or reset task cancels everything in flight
   always_ff @(posedge core_clk) begin
      if (sys_rst) begin
         pending_ff  <= 1'b0;
         pendTask_ff <= 4'h0;
         ilCount_ff  <= 7'h00;
         runTask_ff  <= 4'h0;
         running_ff  <= 1'b0;
      end else if (quietSet) begin                         // [RULE_23]
         pending_ff <= 1'b0;
         ilCount_ff <= 7'h00;
         running_ff <= 1'b0;
      end else begin
         if (realTask) begin
            pending_ff  <= 1'b1;
            pendTask_ff <= newTask;
         end else if (txLoad | rxDone) begin
            pending_ff <= 1'b0;
         end
         if (txLoad) begin
            ilCount_ff <= loadSyms;
            runTask_ff <= pendTask_ff;
            running_ff <= 1'b1;
         end else if (isTx & symTick & (ilCount_ff != 7'h00)) begin
            ilCount_ff <= ilCount_ff - 7'h01;
            if (ilCount_ff == 7'h01) running_ff <= 1'b0;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Status flags; hardware sets win over read clears
   logic irqPend_ff;
   logic bufFree_ff;
   logic ilEmpty_ff;
   logic deinterleave_overflow_flag_ff;
   logic checksum_error_flag_ff;
   logic statusRead;
   wire  bfreeRise = ~bufFree_ff & (txLoad | rxDone);           // [RULE_07]
   wire  ilEmptyRise = isTx & ~ilEmpty_ff & ~pending_ff & symTick &
                       (ilCount_ff == msf_pkg::LOW_MARK);       // [RULE_09]
   wire  dibRise = ~deinterleave_overflow_flag_ff & rxLateTask;                     // [RULE_12]
   wire  irqSet = bfreeRise | ilEmptyRise | dibRise;  // [RULE_01][RULE_02][RULE_03]
   wire  crcTask = (doneTask == msf_pkg::TSK_SYNC_SEARCH_HEADER_TASK) |
                   (doneTask == msf_pkg::TSK_RHB) |
                   (doneTask == msf_pkg::TSK_MID_LAST_RECEIVE_TASK);

   always_ff @(posedge core_clk) begin
      if (sys_rst) begin
         irqPend_ff <= 1'b0;
         bufFree_ff <= 1'b1;
         ilEmpty_ff <= 1'b1;
         deinterleave_overflow_flag_ff  <= 1'b0;
         checksum_error_flag_ff  <= 1'b0;
      end else begin
         if (irqSet) irqPend_ff <= 1'b1;
         else if (statusRead) irqPend_ff <= 1'b0;               // [RULE_04]
         if (quietSet) bufFree_ff <= 1'b1;                      // [RULE_08]
         else if (realTask) bufFree_ff <= 1'b0;                 // [RULE_06]
         else if (txLoad | rxDone) bufFree_ff <= 1'b1;          // [RULE_07]
         if (quietSet) ilEmpty_ff <= 1'b1;                      // [RULE_09]
         else if (txLoad) ilEmpty_ff <= 1'b0;                   // [RULE_10]
         else if (ilEmptyRise) ilEmpty_ff <= 1'b1;              // [RULE_09]
         if (quietSet) deinterleave_overflow_flag_ff <= 1'b0;                       // [RULE_13]
         else if (rxLateTask) deinterleave_overflow_flag_ff <= 1'b1;                // [RULE_12]
         else if (statusRead) deinterleave_overflow_flag_ff <= 1'b0;                // [RULE_13]
         if (quietSet) checksum_error_flag_ff <= 1'b0;                       // [RULE_14]
         else if (rxDone & crcTask) checksum_error_flag_ff <= rxCrcBad;      // [RULE_14]
      end
   end

   // Mode-dependent flags read as zero on the other side; low bits reserved
   wire [7:0] statusByte = {irqPend_ff, bufFree_ff, ilEmpty_ff & isTx,
                            deinterleave_overflow_flag_ff & ~isTx, checksum_error_flag_ff & ~isTx,
                            3'b000};                       // [RULE_10][RULE_24]

   // Open drain: released as soon as the read clears pending
   assign interruptOutLow = 1'b0;
   assign interruptOutOe  = irqPend_ff & mode_ff.intEnable;     // [RULE_05]

   ////////////////////////////////////////////////////////////////////////
   // Received quality: mean error over blocks of 64 symbols
   logic [13:0] qualSum_ff;
   logic [5:0]  qualIdx_ff;
   logic [4:0]  quality_ff;
   wire  [13:0] qualAdd = qualSum_ff + {6'h00, rxErrMag};
   wire         qualEnd = ~isTx & symTick & (qualIdx_ff == msf_pkg::QUAL_WIN);

   always_ff @(posedge core_clk) begin
      if (sys_rst) begin
         qualSum_ff <= 14'h0000;
         qualIdx_ff <= 6'h00;
         quality_ff <= 5'h00;
      end else if (~isTx & symTick) begin
         qualIdx_ff <= qualIdx_ff + 6'h01;
         qualSum_ff <= qualEnd ? 14'h0000 : qualAdd;
         if (qualEnd) quality_ff <= ~qualAdd[13:9];             // [RULE_15]
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Header and frame checksums, fed byte-wise through the data register
   logic [15:0] hdrSum_ff;
   logic [31:0] frmSum_ff;
   // Form bit of the command being written governs its own preset
   wire         formZero = wrCmd ? newCmd.crcZero : cmd_ff.crcZero;
   wire  [15:0] preset16 = formZero ? 16'h0000 : 16'hFFFF;        // [RULE_19]
   wire  [31:0] preset32 = formZero ? 32'h00000000
                                    : 32'hFFFFFFFF;               // [RULE_19]
   wire         hdrStart = realTask & ((newTask == msf_pkg::TSK_THB) |
                                       (newTask == msf_pkg::TSK_SYNC_SEARCH_HEADER_TASK) |
                                       (newTask == msf_pkg::TSK_RHB));
   wire         frmKeep = isTx ? ((doneTask == msf_pkg::TSK_NULL) |
                                  (doneTask == msf_pkg::TSK_TIB) |
                                  (doneTask == msf_pkg::TSK_TLB))
                               : ((doneTask == msf_pkg::TSK_NULL) |
                                  (doneTask == msf_pkg::TSK_MID_LAST_RECEIVE_TASK));

   function automatic logic [15:0] crc16Byte(input logic [15:0] c,
                                             input logic [7:0]  d);
      logic [15:0] r;
      r = c;
      for (int i = 7; i >= 0; i--)
         r = {r[14:0], 1'b0} ^ ((r[15] ^ d[i]) ? msf_pkg::POLY16 : 16'h0000);
      return r;
   endfunction

   function automatic logic [31:0] crc32Byte(input logic [31:0] c,
                                             input logic [7:0]  d);
      logic [31:0] r;
      r = c;
      for (int i = 7; i >= 0; i--)
         r = {r[30:0], 1'b0} ^
             ((r[31] ^ d[i]) ? msf_pkg::POLY32 : 32'h00000000);
      return r;
   endfunction

   always_ff @(posedge core_clk) begin
      if (sys_rst) begin
         hdrSum_ff <= 16'hFFFF;
         frmSum_ff <= 32'hFFFFFFFF;
      end else begin
         if (hdrStart | quietSet) hdrSum_ff <= preset16;
         else if (wrData) hdrSum_ff <= crc16Byte(hdrSum_ff, wByte); // [RULE_16]
         if ((taskDone & ~frmKeep) | quietSet)
            frmSum_ff <= preset32;                                 // [RULE_18]
         else if (wrData)
            frmSum_ff <= crc32Byte(frmSum_ff, wByte);              // [RULE_17]
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Transmit shaping input: +3,+1,-1,-3 as 3-bit two's complement 3,1,7,5
   logic [2:0] shape_ff;
   wire  [2:0] symLevel = txSymbol[1] ? (txSymbol[0] ? 3'h3 : 3'h1)
                                      : (txSymbol[0] ? 3'h7 : 3'h5);
   wire        ilHasData = ~ilEmpty_ff;
   wire  [2:0] shapeNext = (~isTx | ~ilHasData) ? msf_pkg::LVL_MID  // [RULE_11]
                         : (cmd_ff.pulseImp & ~symTick) ? msf_pkg::LVL_MID
                         : symLevel;                             // [RULE_22]

   always_ff @(posedge core_clk) begin
      if (sys_rst) shape_ff <= msf_pkg::LVL_MID;
      else shape_ff <= shapeNext;
   end
   assign shapeLevel  = shape_ff;
   assign rxEqImpulse = cmd_ff.pulseImp;                         // [RULE_22]

   ////////////////////////////////////////////////////////////////////////
   // AXI4-Lite read path; status read has side effects
   logic        rValid_ff;
   logic [31:0] rData_ff;
   logic [1:0]  rResp_ff;
   wire  [7:0]  rAddr = {s_axi_araddr[7:2], 2'b00};
   wire         rTake = s_axi_arvalid & ~rValid_ff;
   assign statusRead = rTake & (rAddr == msf_pkg::OFF_STATUS);
   wire         rMapped = (rAddr == msf_pkg::OFF_STATUS) |
                          (rAddr == msf_pkg::OFF_QUALITY) |
                          (rAddr == msf_pkg::OFF_HDRSUM) |
                          (rAddr == msf_pkg::OFF_FRMSUM);
   wire  [31:0] rMux =
      (rAddr == msf_pkg::OFF_STATUS)  ? {24'h000000, statusByte} :
      (rAddr == msf_pkg::OFF_QUALITY) ? {24'h000000, quality_ff, 3'b000} :
      (rAddr == msf_pkg::OFF_HDRSUM)  ? {16'h0000, hdrSum_ff} :
      (rAddr == msf_pkg::OFF_FRMSUM)  ? frmSum_ff : 32'h00000000;

   assign s_axi_arready = ~rValid_ff;
   assign s_axi_rvalid  = rValid_ff;
   assign s_axi_rdata   = rData_ff;
   assign s_axi_rresp   = rResp_ff;

   always_ff @(posedge core_clk) begin
      if (sys_rst) begin
         rValid_ff <= 1'b0;
         rData_ff  <= 32'h00000000;
         rResp_ff  <= 2'h0;
      end else if (rTake) begin
         rValid_ff <= 1'b1;
         rData_ff  <= rMux;
         rResp_ff  <= rMapped ? msf_pkg::RESP_OKAY : msf_pkg::RESP_SLVERR;
      end else if (s_axi_rready) begin
         rValid_ff <= 1'b0;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Checks
   a_irq_on_free: assert property (@(posedge core_clk) disable iff (sys_rst)
      bfreeRise |=> irqPend_ff) else $error("free rise no irq"); // [RULE_07]
   a_quiet_no_irq: assert property (@(posedge core_clk) disable iff (sys_rst)
      (quietSet & ~irqPend_ff & ~statusRead) |=> ~irqPend_ff & bufFree_ff)
      else $error("quiet set raised irq"); // [RULE_08]
   a_read_clears: assert property (@(posedge core_clk) disable iff (sys_rst)
      (statusRead & ~irqSet) |=> ~irqPend_ff)
      else $error("read kept irq"); // [RULE_04]
   a_pin_follows: assert property (@(posedge core_clk) disable iff (sys_rst)
      interruptOutOe == (irqPend_ff & mode_ff.intEnable))
      else $error("pin mismatch"); // [RULE_05]
   a_task_clears: assert property (@(posedge core_clk) disable iff (sys_rst)
      realTask |=> ~bufFree_ff) else $error("free not cleared"); // [RULE_06]
   a_ovf_irq: assert property (@(posedge core_clk) disable iff (sys_rst)
      rxLateTask |=> deinterleave_overflow_flag_ff & irqPend_ff)
      else $error("overflow not flagged"); // [RULE_12]
   a_mode_clear: assert property (@(posedge core_clk) disable iff (sys_rst)
      modeFlip |=> ~deinterleave_overflow_flag_ff & ~checksum_error_flag_ff & ilEmpty_ff)
      else $error("mode flip flags"); // [RULE_13]
   a_mid_level: assert property (@(posedge core_clk) disable iff (sys_rst)
      (isTx & ilEmpty_ff) |=> shapeLevel == msf_pkg::LVL_MID)
      else $error("not mid level"); // [RULE_11]
   a_empty_irq: assert property (@(posedge core_clk) disable iff (sys_rst)
      ilEmptyRise |=> ilEmpty_ff ##0 irqPend_ff)
      else $error("empty no irq"); // [RULE_09]
   a_block_len: assert property (@(posedge core_clk) disable iff (sys_rst)
      (txLoad & ~shortTask) |=> ilCount_ff == 7'h42)
      else $error("block length"); // [RULE_20]
   a_reserved: assert property (@(posedge core_clk) disable iff (sys_rst)
      statusRead |=> rData_ff[2:0] == 3'b000)
      else $error("reserved bits"); // [RULE_24]
   c_tx_block: cover property (@(posedge core_clk) txLoad ##[1:200] txDone);
   c_rx_done: cover property (@(posedge core_clk) rxDone & rxCrcBad);
   c_late: cover property (@(posedge core_clk) rxLateTask);

endmodule

// ===== verilog/msf_pkg.sv
// Constants, register map and carriers for the modem status block
// Summary of operation
// [RULE_01] Buffer-free rising by the modem raises interrupt pending, except reset or mode change
// [RULE_02] Interleave-empty rising raises interrupt pending, except reset or mode change
// [RULE_03] Deinterleave overflow rising always raises interrupt pending
// [RULE_04] Reading the status register clears interrupt pending
// [RULE_05] Interrupt pin pulls low while pending and enabled, released on status read
// [RULE_06] Any task except null or reset clears buffer free
// [RULE_07] Buffer free set with pending: tx when ready, rx when task done
// [RULE_08] Reset task or mode bit change sets buffer free without pending
// [RULE_09] Tx: interleave empty set with pending below two symbols; reset sets quietly
// [RULE_10] Interleave empty cleared within one symbol after a task; reads 0 in rx
// [RULE_11] Tx with interleave buffer empty feeds mid level into shaping filter
// [RULE_12] Rx: late receive task sets overflow with pending; reads 0 in tx
// [RULE_13] Overflow cleared by status read, reset task or mode bit change
// [RULE_14] Rx checksum error updated at end of search, header, mid/last tasks
// [RULE_15] Rx quality over 64 symbols placed in bits 7..3, bits 2..0 zero
// [RULE_16] Header checksum 16-bit, polynomial x16+x12+x5+1, over header bytes
// [RULE_17] Frame checksum 32-bit Ethernet polynomial over mid and last data
// [RULE_18] Frame checksum reinitialised after tasks except null/mid-last rx, null/mid/last tx
// [RULE_19] Checksums preset all ones when form bit 0, all zeros when 1
// [RULE_20] Each block carried as 66 symbols, 96 bits
// [RULE_21] Block symbols pass through interleave buffer before sending
// [RULE_22] Pulse shape bit selects full-width symbols or impulses, and rx equalisation
// [RULE_23] Select bit 1 is transmit, 0 receive; change cancels current task
// [RULE_24] Reserved status bits 2..0 read zero
package msf_pkg;
   localparam logic [7:0] OFF_STATUS  = 8'h00;
   localparam logic [7:0] OFF_QUALITY = 8'h04;
   localparam logic [7:0] OFF_COMMAND = 8'h08;
   localparam logic [7:0] OFF_MODE    = 8'h0C;
   localparam logic [7:0] OFF_DATA    = 8'h10;
   localparam logic [7:0] OFF_HDRSUM  = 8'h14;
   localparam logic [7:0] OFF_FRMSUM  = 8'h18;
   // Task codes in command bits 3..0
   localparam logic [3:0] TSK_NULL  = 4'h0;
   localparam logic [3:0] TSK_RESET = 4'h1;
   localparam logic [3:0] TSK_SYNC_SEARCH_HEADER_TASK  = 4'h2;
   localparam logic [3:0] TSK_RHB   = 4'h3;
   localparam logic [3:0] TSK_MID_LAST_RECEIVE_TASK  = 4'h4;
   localparam logic [3:0] TSK_R4S   = 4'h5;
   localparam logic [3:0] TSK_THB   = 4'h6;
   localparam logic [3:0] TSK_TIB   = 4'h7;
   localparam logic [3:0] TSK_TLB   = 4'h8;
   localparam logic [3:0] TSK_T4S   = 4'h9;
   localparam logic [6:0] BLOCK_SYMS = 7'h42;   // 66 symbols a block
   localparam logic [6:0] SHORT_SYMS = 7'h04;   // Four-symbol task
   localparam logic [6:0] LOW_MARK   = 7'h02;   // Empty below two symbols
   localparam logic [5:0] QUAL_WIN   = 6'h3F;   // 64-symbol window, last idx
   localparam logic [15:0] POLY16 = 16'h1021;
   localparam logic [31:0] POLY32 = 32'h04C11DB7;
   localparam logic [7:0] MODE_RESET = 8'h00;
   localparam logic [7:0] CMD_RESET  = 8'h00;
   localparam logic [1:0] RESP_OKAY   = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;
   localparam logic [2:0] LVL_MID = 3'h0;

   typedef struct packed {
      logic       rsv7;
      logic       rsv6;
      logic       crcZero;
      logic       pulseImp;
      logic [3:0] taskCode;
   } msf_cmd_t;

   typedef struct packed {
      logic       intEnable;
      logic       invertSym;
      logic       txSelect;
      logic       rxEye;
      logic       powersave;
      logic [2:0] rsv;
   } msf_mode_t;
endpackage

// ===== tb/msf_sym_source.sv
// Symbol-rate source standing in for the radio side
`timescale 1ns/100ps
module msf_sym_source (
   input  wire logic       core_clk,
   input  wire logic       sys_rst,
   output logic            symTick,
   output logic [1:0]      txSymbol,
   output logic [7:0]      rxErrMag
);
   logic [1:0] divCnt_ff;
   // One tick every four clocks keeps the tx countdown short
   always_ff @(posedge core_clk) begin
      divCnt_ff <= sys_rst ? 2'h0 : divCnt_ff + 2'h1;
      symTick   <= !sys_rst && divCnt_ff == 2'h3;
      txSymbol  <= sys_rst ? 2'h0 : txSymbol + {1'b0, symTick};
   end
   // Fixed error size, quality stays steady
   assign rxErrMag = 8'h10;
endmodule

// ===== tb/msf_modem_status_test.sv
// Self-checking bench for the modem status block
`timescale 1ns/100ps
module msf_modem_status_test;
   typedef struct packed {
      logic [7:0]  a;
      logic [31:0] d;
      logic [1:0]  r;
   } msf_row_t;
   logic core_clk = 0, sys_rst = 1, symTick, rxTaskDone = 0, rxCrcBad = 0;
   logic rxLate = 0, s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
   logic s_axi_arvalid = 0, s_axi_rready = 0, s_axi_awready, s_axi_wready;
   logic s_axi_bvalid, s_axi_arready, s_axi_rvalid, rxEqImpulse;
   logic interruptOutOe, interruptOutLow;
   logic [7:0]  s_axi_awaddr = 0, s_axi_araddr = 0, rxErrMag;
   logic [31:0] s_axi_wdata = 0, s_axi_rdata, rdVal;
   logic [3:0]  s_axi_wstrb = 0;
   logic [1:0]  s_axi_bresp, s_axi_rresp, txSymbol, rdResp;
   logic [2:0]  shapeLevel;
   int fails = 0, comparisons = 0;
   msf_row_t rows [4] = '{'{msf_pkg::OFF_STATUS, 32'h40, msf_pkg::RESP_OKAY},
      '{msf_pkg::OFF_QUALITY, 32'h0, msf_pkg::RESP_OKAY},
      '{msf_pkg::OFF_FRMSUM, 32'hFFFFFFFF, msf_pkg::RESP_OKAY},
      '{8'h1C, 32'h0, msf_pkg::RESP_SLVERR}};

   always #12.5 core_clk = ~core_clk;

   msf_sym_source part_u (.core_clk, .sys_rst, .symTick, .txSymbol,
      .rxErrMag);
   msf_modem_status dut_u (.core_clk, .sys_rst, .s_axi_awaddr,
      .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
      .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
      .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
      .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .symTick,
      .txSymbol, .rxTaskDone, .rxCrcBad, .rxLate, .rxErrMag, .shapeLevel,
      .rxEqImpulse, .interruptOutLow, .interruptOutOe);

   task automatic end_sim;
      $display("fails %0d comparisons %0d", fails, comparisons);
      if (fails == 0 && comparisons > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
   endtask
   task automatic chk(input string nm, input logic [31:0] e, g);
      comparisons++;
      if (g !== e) begin
         $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
         fails++;
      end
   endtask
   task automatic hang;
      fails++;
      $display("CHECK FAILED wait expected answer seen none");
      end_sim();
   endtask
   // Ready levels are sampled at the falling edge, before the next rise
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic ra, rw, rb;
      s_axi_awaddr <= a; s_axi_wdata <= d; s_axi_wstrb <= 4'hF;
      s_axi_awvalid <= 1; s_axi_wvalid <= 1; s_axi_bready <= 1;
      for (int n = 0; n < 50; n++) begin
         @(negedge core_clk);
         ra = s_axi_awready; rw = s_axi_wready; rb = s_axi_bvalid;
         @(posedge core_clk);
         if (ra) s_axi_awvalid <= 0;
         if (rw) s_axi_wvalid <= 0;
         if (rb) begin
            s_axi_bready <= 0;
            @(posedge core_clk);
            return;
         end
      end
      hang();
   endtask
   task automatic rd(input logic [7:0] a);
      logic ra, rv;
      s_axi_araddr <= a; s_axi_arvalid <= 1; s_axi_rready <= 1;
      for (int n = 0; n < 50; n++) begin
         @(negedge core_clk);
         ra = s_axi_arready; rv = s_axi_rvalid;
         rdVal = s_axi_rdata; rdResp = s_axi_rresp;
         @(posedge core_clk);
         if (ra) s_axi_arvalid <= 0;
         if (rv) begin
            s_axi_rready <= 0;
            @(posedge core_clk);
            return;
         end
      end
      hang();
   endtask
   task automatic stat(input logic [7:0] e);
      rd(msf_pkg::OFF_STATUS);
      chk("status", {24'h0, e}, rdVal);
   endtask
   task automatic waitOe;
      for (int n = 0; n < 200; n++) begin
         @(negedge core_clk);
         if (interruptOutOe === 1'b1) begin
            @(posedge core_clk);
            return;
         end
      end
      hang();
   endtask

   ////////////////////////////////////////////////////////////////////////
   // Main sequence
   initial begin
      repeat (2) @(posedge core_clk);
      sys_rst <= 0;
      @(posedge core_clk);
      // Reset values and an unmapped place
      foreach (rows[i]) begin
         rd(rows[i].a);
         chk("row data", rows[i].d, rdVal);
         chk("row resp", {30'h0, rows[i].r}, {30'h0, rdResp});
      end
      $display("test reset rows done");
      wr(msf_pkg::OFF_MODE, 32'h80);
      wr(msf_pkg::OFF_COMMAND, 32'h03);
      stat(8'h00);
      rxTaskDone <= 1; rxCrcBad <= 1;
      @(posedge core_clk);
      rxTaskDone <= 0;
      waitOe();
      stat(8'hC8);
      chk("irq pin", 32'h0, {31'h0, interruptOutOe});
      chk("pin low", 32'h0, {31'h0, interruptOutLow});
      stat(8'h48);
      rxLate <= 1;
      wr(msf_pkg::OFF_COMMAND, 32'h04);
      rxLate <= 0;
      stat(8'h98);
      stat(8'h08);
      $display("test receive done");
      wr(msf_pkg::OFF_MODE, 32'hA0);
      stat(8'h60);
      wr(msf_pkg::OFF_COMMAND, 32'h09);
      waitOe();
      stat(8'hC0);
      waitOe();
      stat(8'hE0);
      repeat (20) @(posedge core_clk);
      chk("mid level", {29'h0, msf_pkg::LVL_MID}, {29'h0, shapeLevel});
      wr(msf_pkg::OFF_COMMAND, 32'h10);
      chk("impulse", 32'h1, {31'h0, rxEqImpulse});
      wr(msf_pkg::OFF_COMMAND, 32'h26);
      rd(msf_pkg::OFF_HDRSUM);
      chk("hdr preset", 32'h0, rdVal);
      $display("test transmit done");
      end_sim();
   end
endmodule
